// *** rtl/hsr_top.v ***
// operating-state logic: reaction to host stop, run command, lamps and status
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "hsr_defines.vh"
module hsr_top #(
    parameter AW = `HSR_ADDR_W,
    parameter DW = `HSR_DATA_W,
    parameter PW = `HSR_PARAM_W
) (
    // clock and reset
    input  wire          i_clk,
    input  wire          i_rst_n,
    // register port
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    input  wire          i_wr,
    input  wire          i_rd,
    output reg  [DW-1:0] o_rdata,
    // host and loader pins
    input  wire          i_host_stop,
    input  wire          i_prog_loaded,
    // process side
    output reg           o_io_active,
    output reg  [PW-1:0] o_param,
    output reg           o_param_valid,
    // lamps and interrupt
    output reg           o_run_lamp,
    output reg           o_stop_lamp,
    output reg           o_irq
);
    // one-hot operating states
    localparam [2:0] ST_UNLOADED = 3'h1;
    localparam [2:0] ST_STOP     = 3'h2;
    localparam [2:0] ST_RUN      = 3'h4;

    function is_addr;
        input [AW-1:0] a;
        input [AW-1:0] off;
        begin
            is_addr = (a == off);
        end
    endfunction

    function is_run;
        input [2:0] s;
        begin
            is_run = (s == ST_RUN);
        end
    endfunction

    wire host_stop_s;
    wire loaded_s;
    wire host_stop_rise;
    wire host_stop_fall;

    hsr_sync #(
        .W (2)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_prog_loaded, i_host_stop}),
        .o_q     ({loaded_s, host_stop_s})
    );

    hsr_edge u_edge (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_lvl   (host_stop_s),
        .o_rise  (host_stop_rise),
        .o_fall  (host_stop_fall)
    );

    reg  [2:0]          state_reg;
    reg  [2:0]          state_next;
    reg                 run_bit_reg;
    reg                 cfg_en_reg;
    reg  [PW-1:0]       param_reg;
    reg  [`HSR_IRQ_W-1:0] irq_stat_reg;
    reg  [`HSR_IRQ_W-1:0] irq_mask_reg;
    reg  [`HSR_IRQ_W-1:0] irq_ev;
    reg                 loaded_prev_reg;

    wire wr_ctrl   = i_wr & is_addr(i_addr, `HSR_OFF_CTRL);
    wire wr_cfg    = i_wr & is_addr(i_addr, `HSR_OFF_CFG);
    wire wr_param  = i_wr & is_addr(i_addr, `HSR_OFF_PARAM);
    wire wr_mask   = i_wr & is_addr(i_addr, `HSR_OFF_IRQ_MASK);
    wire rd_irq    = i_rd & is_addr(i_addr, `HSR_OFF_IRQ_STAT);
    // a fresh run command is a write of the control word with the run bit set
    wire run_cmd   = wr_ctrl & i_wdata[`HSR_CTRL_RUN];
    wire load_done = loaded_s & ~loaded_prev_reg;

    // next operating state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_UNLOADED: begin
                if (load_done) begin
                    state_next = ST_STOP;
                end
            end
            ST_STOP: begin
                // host in stop blocks a restart; the run command must come after the host runs
                if (run_cmd && !host_stop_s) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                // enabled response keeps run through host stop
                if (host_stop_rise && !cfg_en_reg) begin
                    state_next = ST_STOP;
                end else if (wr_ctrl && !i_wdata[`HSR_CTRL_RUN]) begin
                    state_next = ST_STOP;
                end
            end
            default: begin
                state_next = ST_UNLOADED;
            end
        endcase
        if (!loaded_s) begin
            state_next = ST_UNLOADED;
        end
    end

    // events for the sticky status
    always @* begin
        irq_ev = {`HSR_IRQ_W{1'b0}};
        irq_ev[`HSR_EV_TO_STOP]   = (state_next == ST_STOP) && (state_reg != ST_STOP);
        irq_ev[`HSR_EV_TO_RUN]    = (state_next == ST_RUN) && (state_reg != ST_RUN);
        irq_ev[`HSR_EV_HOST_STOP] = host_stop_rise;
    end

    // next values of the software-visible settings and sticky bits
    reg                   run_bit_next;
    reg                   cfg_en_next;
    reg  [PW-1:0]         param_next;
    reg  [`HSR_IRQ_W-1:0] irq_mask_next;
    wire [`HSR_IRQ_W-1:0] irq_stat_next;
    reg  [DW-1:0]         status_word;
    reg  [DW-1:0]         rdata_next;
    wire                  run_next;
    wire                  param_go_next;

    // outputs follow the next state so lamps and io move with the state register
    assign run_next      = is_run(state_next);
    assign param_go_next = run_next && run_bit_reg;

    // run bit: a write wins over the clear at host restart
    always @* begin
        run_bit_next = run_bit_reg;
        if (wr_ctrl) begin
            run_bit_next = i_wdata[`HSR_CTRL_RUN];
        end else if (host_stop_fall) begin
            // the host output image is cleared on its restart, so the run bit is too
            run_bit_next = 1'b0;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            run_bit_reg <= 1'b0;
        end else begin
            run_bit_reg <= run_bit_next;
        end
    end

    always @* begin
        cfg_en_next = cfg_en_reg;
        if (wr_cfg) begin
            cfg_en_next = i_wdata[`HSR_CFG_ENABLED];
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg_en_reg <= `HSR_CFG_RESET;
        end else begin
            cfg_en_reg <= cfg_en_next;
        end
    end

    always @* begin
        param_next = param_reg;
        if (wr_param) begin
            param_next = i_wdata[PW-1:0];
        end else if (host_stop_fall) begin
            param_next = `HSR_PARAM_RESET;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            param_reg <= `HSR_PARAM_RESET;
        end else begin
            param_reg <= param_next;
        end
    end

    always @* begin
        irq_mask_next = irq_mask_reg;
        if (wr_mask) begin
            irq_mask_next = i_wdata[`HSR_IRQ_W-1:0];
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_mask_reg <= {`HSR_IRQ_W{1'b0}};
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    // sticky bits: an event in the cycle of the clearing read is kept, not lost
    genvar gi;
    generate
        for (gi = 0; gi < `HSR_IRQ_W; gi = gi + 1) begin : g_sticky
            assign irq_stat_next[gi] = irq_ev[gi] | (irq_stat_reg[gi] & ~rd_irq);
        end
    endgenerate

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_stat_reg <= {`HSR_IRQ_W{1'b0}};
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg       <= ST_UNLOADED;
            loaded_prev_reg <= 1'b0;
        end else begin
            state_reg       <= state_next;
            loaded_prev_reg <= loaded_s;
        end
    end

    // status word as the host program sees it
    always @* begin
        status_word                    = {DW{1'b0}};
        status_word[`HSR_ST_RUN]       = is_run(state_reg);
        status_word[`HSR_ST_STOP]      = !is_run(state_reg);
        status_word[`HSR_ST_IO_ACTIVE] = is_run(state_reg);
        status_word[`HSR_ST_LOADED]    = (state_reg != ST_UNLOADED);
        status_word[`HSR_ST_HOST_STOP] = host_stop_s;
    end

    // read data; idle cycles and unmapped words read as zero
    always @* begin
        rdata_next = {DW{1'b0}};
        if (i_rd) begin
            case (1'b1)
                is_addr(i_addr, `HSR_OFF_CTRL): begin
                    rdata_next[`HSR_CTRL_RUN] = run_bit_reg;
                end
                is_addr(i_addr, `HSR_OFF_CFG): begin
                    rdata_next[`HSR_CFG_ENABLED] = cfg_en_reg;
                end
                is_addr(i_addr, `HSR_OFF_PARAM): begin
                    rdata_next[PW-1:0] = param_reg;
                end
                is_addr(i_addr, `HSR_OFF_STATUS): begin
                    rdata_next = status_word;
                end
                is_addr(i_addr, `HSR_OFF_IRQ_STAT): begin
                    rdata_next[`HSR_IRQ_W-1:0] = irq_stat_reg;
                end
                is_addr(i_addr, `HSR_OFF_IRQ_MASK): begin
                    rdata_next[`HSR_IRQ_W-1:0] = irq_mask_reg;
                end
                default: begin
                    rdata_next = {DW{1'b0}};
                end
            endcase
        end
    end

    // registered outputs
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata       <= {DW{1'b0}};
            o_io_active   <= 1'b0;
            o_param       <= {PW{1'b0}};
            o_param_valid <= 1'b0;
            o_run_lamp    <= 1'b0;
            o_stop_lamp   <= 1'b0;
            o_irq         <= 1'b0;
        end else begin
            o_io_active   <= run_next;
            o_run_lamp    <= run_next;
            o_stop_lamp   <= ~run_next;
            // parameters only reach the process while running with the run bit set
            o_param_valid <= param_go_next;
            if (param_go_next) begin
                o_param <= param_reg;
            end
            // irq tracks the sticky value stored at this same edge
            o_irq         <= |(irq_stat_next & irq_mask_reg);
            o_rdata       <= rdata_next;
        end
    end
endmodule

// *** rtl/hsr_defines.vh ***
// register map, field positions, widths and reset values of the stop-response block
//
// Notes on behaviour
// - one setting selects disabled or enabled response
// - unconfigured setting means disabled response
// - disabled: host stop forces stop, io passive
// - enabled: host stop keeps run, io active
// - disabled: leave stop only on run command
// - parameters used only while run bit set
// - after program load stay stopped until run
// - status word reports current operating state
`ifndef HSR_DEFINES_VH
`define HSR_DEFINES_VH

`define HSR_ADDR_W         4
`define HSR_DATA_W         32

`define HSR_OFF_CTRL       4'h0
`define HSR_OFF_CFG        4'h1
`define HSR_OFF_PARAM      4'h2
`define HSR_OFF_STATUS     4'h3
`define HSR_OFF_IRQ_STAT   4'h4
`define HSR_OFF_IRQ_MASK   4'h5

// control word bits
`define HSR_CTRL_RUN       0
// configuration bits
`define HSR_CFG_ENABLED    0
`define HSR_CFG_RESET      1'h0

// status word bits
`define HSR_ST_RUN         0
`define HSR_ST_STOP        1
`define HSR_ST_IO_ACTIVE   2
`define HSR_ST_LOADED      3
`define HSR_ST_HOST_STOP   4

// interrupt events
`define HSR_IRQ_W          3
`define HSR_EV_TO_STOP     0
`define HSR_EV_TO_RUN      1
`define HSR_EV_HOST_STOP   2

`define HSR_PARAM_W        16
`define HSR_PARAM_RESET    16'h0000

`endif

// *** rtl/hsr_sync.v ***
// two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module hsr_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         i_clk,
    input  wire         i_rst_n,
    // level in and out
    input  wire [W-1:0] i_d,
    output reg  [W-1:0] o_q
);
    reg [W-1:0] meta_reg;

    // first stage is read only by the second
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_reg <= {W{1'b0}};
            o_q      <= {W{1'b0}};
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end
endmodule

// *** rtl/hsr_edge.v ***
// rising and falling edge detector on an already synchronised level
`timescale 1ns/1ps
module hsr_edge (
    // clock and reset
    input  wire i_clk,
    input  wire i_rst_n,
    // level in, one-cycle pulses out
    input  wire i_lvl,
    output wire o_rise,
    output wire o_fall
);
    reg prev_reg;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= i_lvl;
        end
    end

    assign o_rise = i_lvl & ~prev_reg;
    assign o_fall = ~i_lvl & prev_reg;
endmodule

// *** tb/hsr_host_model.sv ***
// host controller model: owns the stop level seen by the block
`timescale 1ns/1ps
module hsr_host_model (
    input  wire i_clk,
    input  wire i_req,
    output reg  o_host_stop
);
    // the level only moves just after an edge and then stands for many cycles
    initial o_host_stop = 1'b0;
    always @(posedge i_clk) o_host_stop <= i_req;
endmodule

// *** tb/hsr_top_sva.sv ***
// port assertions for the stop-response block
`timescale 1ns/1ps
module hsr_chk (
    input wire        i_clk,
    input wire        i_rst_n,
    input wire [3:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire        i_host_stop,
    input wire        i_prog_loaded,
    input wire        o_io_active,
    input wire        o_param_valid,
    input wire        o_run_lamp,
    input wire        o_stop_lamp,
    input wire        o_irq
);
    reg       cfg_reg;
    reg [2:0] mask_reg;
    reg [1:0] quiet_reg;
    wire      run_cmd = i_wr && i_addr == 4'h0 && i_wdata[0];
    // shadow settings, and cycles since the last run command (saturates)
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg_reg   <= 1'b0;
            mask_reg  <= 3'h0;
            quiet_reg <= 2'h0;
        end else begin
            if (i_wr && i_addr == 4'h1) cfg_reg <= i_wdata[0];
            if (i_wr && i_addr == 4'h5) mask_reg <= i_wdata[2:0];
            quiet_reg <= run_cmd ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_lamp_excl:
        assert property (!(o_run_lamp && o_stop_lamp)) else $error("both lamps lit");
    chk_io_follow:
        assert property (o_io_active == o_run_lamp) else $error("io not tied to run");
    chk_valid_run:
        assert property (o_param_valid |-> o_run_lamp) else $error("param valid in stop");
    chk_read_idle:
        assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data without read");
    chk_stop_disabled:
        assert property ((o_run_lamp && !cfg_reg && $rose(i_host_stop)) ##1 i_host_stop [*4]
            |-> o_stop_lamp) else $error("no stop on host stop");
    chk_stay_enabled:
        assert property ((o_run_lamp && cfg_reg && $rose(i_host_stop) && !i_wr) ##1 !i_wr [*4]
            |-> o_run_lamp) else $error("left run on host stop");
    chk_stop_hold:
        assert property (o_stop_lamp && quiet_reg == 2'h3 && !run_cmd |=> o_stop_lamp)
            else $error("left stop without command");
    chk_mask_quiet:
        assert property (mask_reg == 3'h0 ##1 mask_reg == 3'h0 |-> !o_irq)
            else $error("masked irq raised");
    chk_unloaded:
        assert property (!i_prog_loaded [*5] |-> !o_run_lamp) else $error("run while unloaded");
endmodule
bind hsr_top hsr_chk u_chk (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_host_stop, .i_prog_loaded, .o_io_active, .o_param_valid, .o_run_lamp, .o_stop_lamp,
    .o_irq);

// *** tb/hsr_top_test.sv ***
// self-checking bench for the stop-response block
`timescale 1ns/1ps
module hsr_top_test;
    reg         i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_prog_loaded = 0, stop_req = 0;
    reg  [3:0]  i_addr = 0;
    reg  [31:0] i_wdata = 0, seed = 32'h00010c61, v;
    wire [31:0] o_rdata;
    wire [15:0] o_param;
    wire        i_host_stop, o_io_active, o_param_valid, o_run_lamp, o_stop_lamp, o_irq;
    integer     num_errors = 0, checks_done = 0, cycles = 0, k;
    hsr_top dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_host_stop,
        .i_prog_loaded, .o_io_active, .o_param, .o_param_valid, .o_run_lamp, .o_stop_lamp,
        .o_irq);
    hsr_host_model host (.i_clk, .i_req(stop_req), .o_host_stop(i_host_stop));
    initial forever #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            report_and_stop;
        end
    end
    function automatic [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function [31:0] st(input run, input ld, input h);
        st = {27'h0, h, ld, run, !run, run};
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one strobe cycle; read data is taken in the cycle after the strobe
    task bus(input w, input [3:0] a, input [31:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= w;
        i_rd    <= !w;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        i_rd    <= 1'b0;
        @(negedge i_clk);
        v = o_rdata;
    endtask
    task idle(input integer n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task hs(input b);
        @(posedge i_clk);
        stop_req <= b;
        idle(6);
    endtask
    task look(input run, input ld, input h);
        chk({o_run_lamp, o_stop_lamp, o_io_active}, {run, !run, run});
        bus(0, 4'h3, 0);
        chk(v, st(run, ld, h));
    endtask
    task go(input [31:0] p);
        bus(1, 4'h2, p);
        bus(1, 4'h0, 1);
        idle(3);
        chk({o_param_valid, o_param}, {1'b1, p[15:0]});
    endtask
    task report_and_stop;
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        bus(0, 4'h1, 0);
        chk(v, 0);
        bus(1, 4'h0, 1);
        idle(3);
        look(0, 0, 0);
        bus(1, 4'h0, 0);
        @(posedge i_clk) i_prog_loaded <= 1'b1;
        idle(4);
        look(0, 1, 0);
        for (k = 0; k < 4; k++) begin
            seed = xs(seed);
            go(seed);
        end
        look(1, 1, 0);
        hs(1);
        look(0, 1, 1);
        chk(o_param_valid, 0);
        bus(1, 4'h0, 1);
        idle(3);
        look(0, 1, 1);
        hs(0);
        look(0, 1, 0);
        go(xs(seed));
        bus(0, 4'h4, 0);
        chk(v, 32'h00000007);
        bus(1, 4'h5, 7);
        bus(1, 4'h1, 1);
        bus(0, 4'h1, 0);
        chk(v, 32'h00000001);
        hs(1);
        look(1, 1, 1);
        chk(o_irq, 1);
        bus(0, 4'h4, 0);
        chk({v[7:0], o_irq}, 9'h008);
        hs(0);
        chk({o_run_lamp, o_param_valid}, 2'b10);
        go(seed >> 9);
        bus(1, 4'h5, 0);
        hs(1);
        chk({o_irq, o_run_lamp}, 2'b01);
        bus(1, 4'hf, -1);
        bus(0, 4'hf, 0);
        chk(v, 0);
        report_and_stop;
    end
endmodule
